// [sfcrp_pkg.sv]
// Constants, opcodes and state type of the serial flash command port
package sfcrp_pkg;
  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned FIFO_DEPTH   = 16;
  localparam int unsigned ADDR_BYTES   = 3;
  localparam logic [2:0]  HDR_LAST_BYTE = 3'h3;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [2:0]  OPC_ONLY_LEN = 3'h1;
  localparam logic [23:0] ADDR_ONE     = 24'h00_0001;
  localparam logic [23:0] ADDR_RST     = 24'h00_0000;
  localparam logic [7:0]  BYTE_RST     = 8'h00;

  // Opcodes
  localparam logic [7:0] OPC_READ         = 8'h03;
  localparam logic [7:0] OPC_FAST_READ    = 8'h0B;
  localparam logic [7:0] OPC_PAR_ENTRY    = 8'h55;
  localparam logic [7:0] OPC_PAR_EXIT     = 8'h45;
  localparam logic [7:0] OPC_WRITE_LATCH_SET   = 8'h06;
  localparam logic [7:0] OPC_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] OPC_BULK_ERASE   = 8'hC7;
  localparam logic [7:0] OPC_DEEP_POWER_DOWN    = 8'hB9;
  localparam logic [7:0] OPC_RELEASE_POWER_DOWN = 8'hAB;
  localparam logic [7:0] OPC_IDENT_READ   = 8'h9F;
  localparam logic [7:0] OPC_MAKER_CODE_READ = 8'h90;

  typedef enum logic [2:0] {
    SFCRP_IDLE   = 3'b000,
    SFCRP_ADDR   = 3'b001,
    SFCRP_DUMMY  = 3'b010,
    SFCRP_DATA   = 3'b011,
    SFCRP_IGNORE = 3'b100
  } sfcrp_state_t;
endpackage : sfcrp_pkg

// [sfcrp_fifo.sv]
// Parameterised valid/ready FIFO with synchronous flush
`timescale 1ns/1ps
module sfcrp_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 16
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_flush,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          wr;
  logic          rd;

  assign o_in_ready  = (cnt_r != D[AW:0]);
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rp_r];
  assign wr          = i_in_valid & o_in_ready;
  assign rd          = i_out_ready & o_out_valid;

  always_ff @(posedge i_clk) begin
    if (wr) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || i_flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wr ? wp_r + 1'b1 : wp_r;
      rp_r  <= rd ? rp_r + 1'b1 : rp_r;
      cnt_r <= cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    end
  end
endmodule : sfcrp_fifo

// [sfcrp_top.sv]
// Serial flash command front end: framing, parallel mode and array reads
// Behaviour
// RULE1 - Opcode 55h puts the output path into byte-wide parallel mode.
// RULE2 - In parallel mode only the listed command set is accepted.
// RULE3 - Opcode 45h or a power cycle returns the device to serial mode.
// RULE4 - Host keeps clock at 6 MHz reads, 10 MHz others in parallel.
// RULE5 - High-speed read is not performed while in parallel mode.
// RULE6 - All bytes travel most significant bit first, both directions.
// RULE7 - First eight rising-edge samples after select form the opcode.
// RULE8 - Commands are opcode plus optional address/data; select ends writes.
// RULE9 - Read output stops as soon as chip select rises.
// RULE10 - Write-type commands run only if select rises on a byte boundary.
// RULE11 - Array accesses are ignored while program, erase or status write run.
// RULE12 - Normal read is opcode 03h plus 24-bit address; host clock 40 MHz.
// RULE13 - Read data bits leave on the falling clock edge.
// RULE14 - Read address increments per byte and wraps to zero at the top.
// RULE15 - Normal read during a busy internal operation is rejected.
// RULE16 - Parallel mode gives a whole byte per clock, same sequence.
// RULE17 - Parallel read: opcode, three address bytes, data from fifth byte.
// RULE18 - High-speed read 0Bh: address, one dummy byte, then data.
// RULE19 - High-speed read during a busy internal operation is rejected.
// RULE20 - Output lines stay released except while returning read data.
`timescale 1ns/1ps
module sfcrp_top
  import sfcrp_pkg::*;
(
  // Clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_SRST,
  // Serial port
  input  wire logic        I_CS_N,
  input  wire logic        I_SCK,
  input  wire logic        I_SI,
  output logic             O_SO,
  output logic             O_SO_OE_N,
  // Parallel output path
  output logic [7:0]       O_PARALLEL_DATA_OUT,
  output logic             O_PDO_OE_N,
  output logic             O_PARALLEL_MODE,
  // Array fetch port
  input  wire logic        I_ARRAY_BUSY,
  output logic             O_ARR_REQ,
  output logic [23:0]      O_ARR_ADDR,
  input  wire logic        I_ARR_VALID,
  input  wire logic [7:0]  I_ARR_DATA,
  // Committed write-type commands
  output logic             O_CMD_VALID,
  output logic [7:0]       O_CMD_CODE
);

  function automatic logic is_write_cmd(input logic [7:0] opc);
    is_write_cmd = (opc == OPC_WRITE_LATCH_SET)   ||
                   (opc == OPC_WRITE_LATCH_CLEAR) ||
                   (opc == OPC_PAGE_PROGRAM)      ||
                   (opc == OPC_SECTOR_ERASE)      ||
                   (opc == OPC_BULK_ERASE)        ||
                   (opc == OPC_STATUS_WRITE);
  endfunction : is_write_cmd

  function automatic logic par_allowed(input logic [7:0] opc);
    par_allowed = is_write_cmd(opc)                 ||
                  (opc == OPC_READ)                 ||
                  (opc == OPC_STATUS_READ)          ||
                  (opc == OPC_DEEP_POWER_DOWN)      ||
                  (opc == OPC_RELEASE_POWER_DOWN)   ||
                  (opc == OPC_IDENT_READ)           ||
                  (opc == OPC_MAKER_CODE_READ)      ||
                  (opc == OPC_PAR_EXIT);
  endfunction : par_allowed

  function automatic logic [23:0] addr_inc(input logic [23:0] a);
    addr_inc = a + ADDR_ONE;
  endfunction : addr_inc

  sfcrp_state_t state_r;
  logic         sck_r;
  logic         cs_r;
  logic [6:0]   in_sh_r;
  logic [2:0]   bit_r;
  logic [2:0]   byte_r;
  logic [7:0]   opc_r;
  logic [23:0]  addr_r;
  logic         fetch_on_r;
  logic         par_r;
  logic         drive_r;
  logic [2:0]   obit_r;
  logic [6:0]   out_sh_r;
  logic         so_r;
  logic [7:0]   pdo_r;
  logic         cmd_valid_r;
  logic [7:0]   cmd_code_r;

  logic         sck_rise;
  logic         sck_fall;
  logic         cs_rise;
  logic         byte_done;
  logic [7:0]   in_byte;
  logic         on_boundary;
  logic         pop;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic [7:0]   fifo_out_data;

  // Pins are taken as synchronous; one flop gives edge detection
  assign sck_rise    = ~I_CS_N & I_SCK & ~sck_r;
  assign sck_fall    = ~I_CS_N & ~I_SCK & sck_r;
  assign cs_rise     = I_CS_N & ~cs_r;
  assign byte_done   = sck_rise & (bit_r == BIT_LAST);
  assign in_byte     = {in_sh_r, I_SI}; // RULE6
  assign on_boundary = (bit_r == 3'h0) & (byte_r != 3'h0); // RULE10
  assign pop         = sck_fall & (state_r == SFCRP_DATA) &
                       (par_r | (obit_r == 3'h0));

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      sck_r <= 1'b0;
      cs_r  <= 1'b1;
    end else begin
      sck_r <= I_SCK;
      cs_r  <= I_CS_N;
    end
  end

  // Input framing: bit and byte counts since select fell
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST || I_CS_N) begin
      in_sh_r <= 7'h00;
      bit_r   <= 3'h0;
      byte_r  <= 3'h0;
    end else if (sck_rise) begin // RULE7
      in_sh_r <= in_byte[6:0];
      bit_r   <= bit_r + 3'h1;
      if (byte_done && byte_r != BIT_LAST) begin
        byte_r <= byte_r + 3'h1;
      end
    end
  end

  // Command sequencing
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST || I_CS_N) begin
      state_r <= SFCRP_IDLE; // RULE9
      opc_r   <= (I_SRST) ? BYTE_RST : opc_r;
    end else if (byte_done) begin
      case (state_r)
        SFCRP_IDLE: begin
          opc_r <= in_byte; // RULE7
          if (I_ARRAY_BUSY) begin
            state_r <= SFCRP_IGNORE; // RULE11 RULE15 RULE19
          end else if (in_byte == OPC_READ) begin
            state_r <= SFCRP_ADDR; // RULE12 RULE17
          end else if (in_byte == OPC_FAST_READ && !par_r) begin
            state_r <= SFCRP_ADDR; // RULE18
          end else begin
            state_r <= SFCRP_IGNORE; // RULE5
          end
        end
        SFCRP_ADDR: begin
          if (byte_r == HDR_LAST_BYTE) begin
            state_r <= (opc_r == OPC_FAST_READ) ? SFCRP_DUMMY
                                                : SFCRP_DATA; // RULE18
          end
        end
        SFCRP_DUMMY: state_r <= SFCRP_DATA;
        SFCRP_DATA:  state_r <= SFCRP_DATA;
        SFCRP_IGNORE: state_r <= SFCRP_IGNORE;
        default:     state_r <= SFCRP_IDLE;
      endcase
    end
  end

  // Address capture and fetch address counter
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      addr_r     <= ADDR_RST;
      fetch_on_r <= 1'b0;
    end else if (I_CS_N) begin
      fetch_on_r <= 1'b0; // RULE9
    end else if (byte_done && state_r == SFCRP_ADDR) begin
      addr_r <= {addr_r[15:0], in_byte}; // RULE6 RULE12
      if (byte_r == HDR_LAST_BYTE) begin
        fetch_on_r <= 1'b1;
      end
    end else if (O_ARR_REQ && I_ARR_VALID) begin
      addr_r <= addr_inc(addr_r); // RULE14
    end
  end

  // Prefetch runs ahead; FIFO back-pressure stalls the fetch
  assign O_ARR_REQ  = fetch_on_r & fifo_in_ready;
  assign O_ARR_ADDR = addr_r;

  sfcrp_fifo #(
    .W (BYTE_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_SYS_CLK),
    .i_srst      (I_SRST),
    .i_flush     (I_CS_N),
    .i_in_valid  (fetch_on_r & I_ARR_VALID),
    .i_in_data   (I_ARR_DATA),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (pop)
  );

  // Output shifting on falling clock edges
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST || I_CS_N) begin
      obit_r   <= 3'h0;
      out_sh_r <= 7'h00;
      so_r     <= 1'b0;
      pdo_r    <= BYTE_RST;
      drive_r  <= 1'b0;
    end else if (sck_fall && state_r == SFCRP_DATA) begin // RULE13
      drive_r <= 1'b1;
      if (par_r) begin
        pdo_r <= fifo_out_data; // RULE16
      end else if (obit_r == 3'h0) begin
        so_r     <= fifo_out_data[7]; // RULE6
        out_sh_r <= fifo_out_data[6:0];
        obit_r   <= 3'h1;
      end else begin
        so_r     <= out_sh_r[6];
        out_sh_r <= {out_sh_r[5:0], 1'b0};
        obit_r   <= obit_r + 3'h1;
      end
    end
  end

  // Parallel mode only clears on exit command or power cycle reset
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      par_r <= 1'b0; // RULE3
    end else if (cs_rise && on_boundary && byte_r == OPC_ONLY_LEN) begin
      if (opc_r == OPC_PAR_ENTRY && !par_r) begin
        par_r <= 1'b1; // RULE1
      end else if (opc_r == OPC_PAR_EXIT) begin
        par_r <= 1'b0; // RULE3
      end
    end
  end

  // Write-type commands commit only when select rises at a byte boundary
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      cmd_valid_r <= 1'b0;
      cmd_code_r  <= BYTE_RST;
    end else begin
      cmd_valid_r <= cs_rise && on_boundary && is_write_cmd(opc_r) &&
                     (!par_r || par_allowed(opc_r)); // RULE8 RULE10 RULE2
      if (cs_rise) begin
        cmd_code_r <= opc_r;
      end
    end
  end

  assign O_SO                = so_r;
  assign O_SO_OE_N           = ~(drive_r & ~par_r); // RULE20
  assign O_PARALLEL_DATA_OUT = pdo_r;
  assign O_PDO_OE_N          = ~(drive_r & par_r); // RULE20
  assign O_PARALLEL_MODE     = par_r;
  assign O_CMD_VALID         = cmd_valid_r;
  assign O_CMD_CODE          = cmd_code_r;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);

  a_par_entry_sets: assert property ( // RULE1
    cs_rise && on_boundary && byte_r == OPC_ONLY_LEN &&
    opc_r == OPC_PAR_ENTRY |=> par_r ##1 O_PARALLEL_MODE)
    else $error("parallel entry did not set mode");

  a_par_exit_clears: assert property ( // RULE3
    cs_rise && on_boundary && byte_r == OPC_ONLY_LEN &&
    opc_r == OPC_PAR_EXIT |=> !O_PARALLEL_MODE)
    else $error("parallel exit did not clear mode");

  a_fast_par_blocked: assert property ( // RULE5
    byte_done && state_r == SFCRP_IDLE && in_byte == OPC_FAST_READ &&
    par_r |=> state_r == SFCRP_IGNORE [*1] ##1 !fetch_on_r)
    else $error("fast read accepted in parallel mode");

  a_opcode_capture: assert property ( // RULE7
    byte_done && state_r == SFCRP_IDLE |=> opc_r == $past(in_byte))
    else $error("opcode not captured from eight samples");

  a_cs_ends_read: assert property ( // RULE9
    I_CS_N |=> state_r == SFCRP_IDLE && !O_ARR_REQ &&
    O_SO_OE_N && O_PDO_OE_N)
    else $error("read not ended by chip select");

  a_write_boundary: assert property ( // RULE10
    O_CMD_VALID |-> $past(cs_rise) && $past(bit_r) == 3'h0 &&
    is_write_cmd(O_CMD_CODE))
    else $error("write command committed off byte boundary");

  a_busy_rejects: assert property ( // RULE11
    byte_done && state_r == SFCRP_IDLE && I_ARRAY_BUSY
    |=> state_r == SFCRP_IGNORE ##1 !fetch_on_r)
    else $error("array access accepted while busy");

  a_addr_wraps: assert property ( // RULE14
    O_ARR_REQ && I_ARR_VALID && !I_CS_N
    |=> O_ARR_ADDR == addr_inc($past(O_ARR_ADDR)))
    else $error("fetch address did not step by one");

  a_hiz_outside: assert property ( // RULE20
    state_r != SFCRP_DATA |-> O_SO_OE_N && O_PDO_OE_N)
    else $error("output driven outside read data");

  a_serial_msb: assert property ( // RULE13
    pop && !par_r |=> O_SO == $past(fifo_out_data[7]) && !O_SO_OE_N)
    else $error("serial byte not started with msb");

  a_par_byte: assert property ( // RULE16
    pop && par_r |=> O_PARALLEL_DATA_OUT == $past(fifo_out_data) &&
    !O_PDO_OE_N)
    else $error("parallel byte not presented");

  a_par_holds: assert property ( // RULE3
    O_PARALLEL_MODE && !(cs_rise && opc_r == OPC_PAR_EXIT)
    |=> O_PARALLEL_MODE)
    else $error("parallel mode left without exit command");

  a_serial_shift: assert property ( // RULE13
    sck_fall && state_r == SFCRP_DATA && !par_r && obit_r != 3'h0
    |=> O_SO == $past(out_sh_r[6]))
    else $error("serial bit not shifted on falling edge");

  a_addr_shift_in: assert property ( // RULE12
    byte_done && state_r == SFCRP_ADDR
    |=> O_ARR_ADDR[7:0] == $past(in_byte))
    else $error("address byte not shifted in");

  a_off_boundary: assert property ( // RULE10
    cs_rise && bit_r != 3'h0 |=> !O_CMD_VALID)
    else $error("write command committed mid byte");

  a_cmd_one_cycle: assert property ( // RULE10
    O_CMD_VALID |=> !O_CMD_VALID)
    else $error("commit strobe held longer than one cycle");

  a_dummy_skip: assert property ( // RULE18
    byte_done && state_r == SFCRP_DUMMY |=> state_r == SFCRP_DATA)
    else $error("dummy byte not followed by data");

endmodule : sfcrp_top

// [sfcrp_array_model.sv]
// Behavioural memory array behind the fetch port, prompt or stalling
`timescale 1ns/1ps
module sfcrp_array_model (
  // Clock
  input  wire logic        i_clk,
  // Fetch port
  input  wire logic        i_req,
  input  wire logic [23:0] i_addr,
  input  wire logic        i_slow,
  output logic             o_valid,
  output logic [7:0]       o_data
);
  logic       tick_r = 1'b0;
  logic [7:0] last_r = 8'h00;
  // Slow mode answers every other cycle only, to stall the fill side
  assign o_valid = i_req & (~i_slow | tick_r);
  // Idle data is the inverse of the last byte, never a stale copy
  // Top address byte mixed in so a wrong wrap shows in the data
  assign o_data = o_valid ? (i_addr[7:0] ^ i_addr[15:8] ^ i_addr[23:16] ^
                             8'h5A) : ~last_r;
  always_ff @(posedge i_clk) begin
    tick_r <= ~tick_r;
    if (o_valid) last_r <= o_data;
  end
endmodule : sfcrp_array_model

// [serial_flash_cmd_read_port_tb_top.sv]
// Self-checking bench for the serial flash command front end
`timescale 1ns/1ps
module serial_flash_cmd_read_port_tb_top;
  import sfcrp_pkg::*;
  logic        clk  = 1'b0;
  logic        srst = 1'b1;
  logic        cs_n = 1'b1;
  logic        sck  = 1'b0;
  logic        si   = 1'b0;
  logic        busy = 1'b0;
  logic        slow = 1'b0;
  logic        so, so_oe_n, pdo_oe_n, par_mode, arr_req, arr_valid, cmd_valid;
  logic [7:0]  pdo, arr_data, cmd_code, rx, pb;
  logic [23:0] arr_addr;
  logic [7:0]  wc[6] = '{OPC_WRITE_LATCH_SET, OPC_WRITE_LATCH_CLEAR,
                         OPC_PAGE_PROGRAM, OPC_SECTOR_ERASE,
                         OPC_BULK_ERASE, OPC_STATUS_WRITE};
  int          failures    = 0;
  int          checks_done = 0;
  int          pulses      = 0;
  int          hp          = 4;
  int          addr;

  always #2.5 clk = ~clk;

  sfcrp_top u_sfcrp_top (
    .I_SYS_CLK(clk), .I_SRST(srst), .I_CS_N(cs_n), .I_SCK(sck), .I_SI(si),
    .O_SO(so), .O_SO_OE_N(so_oe_n), .O_PARALLEL_DATA_OUT(pdo),
    .O_PDO_OE_N(pdo_oe_n), .O_PARALLEL_MODE(par_mode),
    .I_ARRAY_BUSY(busy), .O_ARR_REQ(arr_req), .O_ARR_ADDR(arr_addr),
    .I_ARR_VALID(arr_valid), .I_ARR_DATA(arr_data),
    .O_CMD_VALID(cmd_valid), .O_CMD_CODE(cmd_code)
  );

  sfcrp_array_model u_sfcrp_array_model (
    .i_clk(clk), .i_req(arr_req), .i_addr(arr_addr), .i_slow(slow),
    .o_valid(arr_valid), .o_data(arr_data)
  );

  // A stuck commit strobe shows up as more than one count per frame
  always @(posedge clk) begin
    if (cmd_valid !== 1'b0) pulses++;
  end

  function automatic logic [7:0] exp_b(input int a);
    return 8'(a ^ (a >> 8) ^ (a >> 16) ^ 'h5A);
  endfunction : exp_b

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // One host clock period: fall, sample late in the low phase, rise
  task automatic sbit(input logic b);
    sck = 1'b0;
    si  = b;
    cyc(hp);
    rx = {rx[6:0], so};
    pb = pdo;
    sck = 1'b1;
    cyc(hp);
  endtask : sbit

  task automatic sbyte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) sbit(v[i]);
  endtask : sbyte

  task automatic cs_hi;
    sck = 1'b0;
    cyc(hp);
    cs_n = 1'b1;
    cyc(hp);
  endtask : cs_hi

  task automatic note(input string s);
    $display("test done: %s", s);
  endtask : note

  task automatic read_chk(input logic [7:0] op, input int a, input int n,
                          input bit par, input bit ok);
    cs_n = 1'b0;
    cyc(2);
    sbyte(op);
    sbyte(a[23:16]);
    sbyte(a[15:8]);
    sbyte(a[7:0]);
    if (op == OPC_FAST_READ) sbyte(8'h00);
    for (int k = 0; k < n; k++) begin
      if (par) sbit(1'b0);
      else sbyte(8'h00);
      if (ok) chk(par ? pb : rx, exp_b(a + k));
      chk({so_oe_n, pdo_oe_n}, par ? {1'b1, !ok} : {!ok, 1'b1});
    end
    // Stop one host clock into the next unit: one bit of a serial byte, or a whole parallel byte
    sbit(1'b0);
    cs_hi;
    chk({so_oe_n, pdo_oe_n}, 2'b11);
  endtask : read_chk

  task automatic wcmd(input logic [7:0] op, input int nb, input bit hit);
    int p;
    p = pulses;
    cs_n = 1'b0;
    cyc(2);
    for (int i = 7; i > 7 - nb; i--) sbit(op[i]);
    cs_hi;
    chk(pulses - p, hit);
    if (hit) chk(cmd_code, op);
  endtask : wcmd

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    report_and_stop;
  end

  initial begin
    void'($urandom(32'h8251));
    cyc(5);
    srst = 1'b0;
    cyc(2);
    chk({par_mode, so_oe_n, pdo_oe_n, arr_req}, 4'b0110);
    note("reset");
    addr = $urandom & 'hFF_FFFF;
    read_chk(OPC_READ, addr, 3, 0, 1);
    slow = 1'b1;
    read_chk(OPC_READ, 'hFF_FFFE, 3, 0, 1);
    read_chk(OPC_FAST_READ, addr, 2, 0, 1);
    slow = 1'b0;
    busy = 1'b1;
    read_chk(OPC_READ, addr, 1, 0, 0);
    read_chk(OPC_FAST_READ, addr, 1, 0, 0);
    busy = 1'b0;
    note("serial reads");
    foreach (wc[i]) begin
      wcmd(wc[i], 8, 1'b1);
      wcmd(wc[i], 7, 1'b0);
    end
    note("write commands");
    // Slower host clock while parallel mode is active
    hp = 17;
    wcmd(OPC_PAR_ENTRY, 8, 1'b0);
    chk(par_mode, 1'b1);
    read_chk(OPC_READ, addr, 4, 1, 1);
    read_chk(OPC_FAST_READ, addr, 1, 1, 0);
    wcmd(OPC_WRITE_LATCH_SET, 8, 1'b1);
    wcmd(OPC_PAR_EXIT, 8, 1'b0);
    chk(par_mode, 1'b0);
    hp = 4;
    read_chk(OPC_READ, addr, 1, 0, 1);
    wcmd(OPC_PAR_ENTRY, 8, 1'b0);
    chk(par_mode, 1'b1);
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(2);
    chk(par_mode, 1'b0);
    note("parallel mode");
    report_and_stop;
  end
endmodule : serial_flash_cmd_read_port_tb_top
